// File: sctp_pkg.sv
// Shared constants for the target-side information transfer logic
package sctp_pkg;

    // ----------------------------------------------------------------
    // Clock and bus delays
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 40;
    localparam int DESKEW_NS       = 45;
    localparam int CABLE_SKEW_NS   = 10;
    localparam int BUS_SETTLE_NS   = 400;
    localparam int DATA_RELEASE_NS = 400;

    // Least times, rounded up to whole cycles
    localparam int SETUP_CYC  = (DESKEW_NS + CABLE_SKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CYC = (BUS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TURN_CYC   = (DATA_RELEASE_NS + BUS_SETTLE_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;

    localparam int TMR_W = 8;
    localparam int CNT_W = 16;

    // ----------------------------------------------------------------
    // Phase codes on MSG, C/D, I/O
    // ----------------------------------------------------------------
    localparam logic [2:0] PH_DATA_OUT = 3'h0;
    localparam logic [2:0] PH_DATA_IN  = 3'h1;
    localparam logic [2:0] PH_COMMAND  = 3'h2;
    localparam logic [2:0] PH_STATUS   = 3'h3;
    localparam logic [2:0] PH_BAD_A    = 3'h4;
    localparam logic [2:0] PH_BAD_B    = 3'h5;
    localparam logic [2:0] PH_MSG_OUT  = 3'h6;
    localparam logic [2:0] PH_MSG_IN   = 3'h7;
    localparam int PH_IO  = 0;
    localparam int PH_CD  = 1;
    localparam int PH_MSG = 2;

    localparam int FIFO_W = 8;
    localparam int FIFO_D = 4;

    typedef enum logic [2:0] {
        ST_FREE, ST_HOLD, ST_SETTLE, ST_TX_SETUP, ST_TX_REQ, ST_TX_REL, ST_RX_REQ, ST_RX_REL
    } sctp_state_e;

endpackage

// File: sctp_sync.sv
// Three-stage synchroniser with agreement filter for bus inputs
`timescale 1ns/1ns
module sctp_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] s1_q, s2_q, s3_q, out_q;
    logic [W-1:0] out_d;

    // First stage feeds only the second; change accepted when stages two and three agree
    always_comb
    begin
        out_d = out_q;
        for (int i = 0; i < W; i++)
        begin
            if (s2_q[i] == s3_q[i])
                out_d[i] = s3_q[i];
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            out_q <= '0;
        end
        else
        begin
            s1_q  <= async_i;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= out_d;
        end
    end

    assign sync_o = out_q;
endmodule

// File: sctp_fifo.sv
// Small valid/ready FIFO for received bytes
`timescale 1ns/1ns
module sctp_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    input  wire logic         flush_i,
    input  wire logic         wr_valid_i,
    output logic              wr_ready_o,
    input  wire logic [W-1:0] wr_data_i,
    output logic              rd_valid_o,
    input  wire logic         rd_ready_i,
    output logic      [W-1:0] rd_data_o
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]   num_q, num_d;
    logic          wr, rd;

    assign wr_ready_o = (num_q != (AW+1)'(D));
    assign rd_valid_o = (num_q != '0);
    assign rd_data_o  = mem_q[rp_q];
    assign wr         = wr_valid_i && wr_ready_o;
    assign rd         = rd_valid_o && rd_ready_i;

    always_comb
    begin
        wp_d  = wp_q;
        rp_d  = rp_q;
        num_d = num_q;
        if (flush_i)
        begin
            wp_d  = '0;
            rp_d  = '0;
            num_d = '0;
        end
        else
        begin
            if (wr)
                wp_d = (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
            if (rd)
                rp_d = (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
            num_d = num_q + (AW+1)'(wr) - (AW+1)'(rd);
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            num_q <= '0;
        end
        else
        begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            num_q <= num_d;
        end
    end

    // Storage carries no reset; occupancy guards it
    always_ff @(posedge ref_clk_i)
    begin
        if (wr && !flush_i)
            mem_q[wp_q] <= wr_data_i;
    end
endmodule

// File: sctp_target.sv
// Target-side information transfer phases with REQ/ACK byte handshake
//
// Function
// - I/O high sends to initiator, low receives
// - Drive data, wait skew, then REQ
// - On ACK drop REQ; next after ACK low
// - Request each byte, capture on ACK
// - Command phase: C/D high, I/O, MSG low
// - Status phase: C/D, I/O high, MSG low
// - Message phases hold whole messages only
// - Message Out handshakes until ATN false
// - BSY, SEL, REQ, ACK steady between phases
// - Turn bus in: wait release plus settle
// - Turn bus out: release within one deskew
// - ATN pending message, answered by Message Out
// - RST overrides every phase
// - On RST discard commands, release reservations
// - Reset or any phase may reach Bus Free
// - Bus Free, arbitration, selection, then transfers; here no arbitration or selection, a start raises BSY, SEL stays low
// - Transfer phases in any order, repeats allowed
// - Phase codes on MSG, C/D, I/O
// - BSY high, phase valid around handshakes
// - One byte per REQ/ACK handshake
`timescale 1ns/1ns
module sctp_target
    import sctp_pkg::*;
(
    input  wire logic                   ref_clk_i,
    input  wire logic                   rst_i,
    // Bus pins, logical true = asserted
    input  wire logic                   ack_i,
    input  wire logic                   atn_i,
    input  wire logic                   scsi_rst_i,
    input  wire logic [7:0]             db_i,
    output logic      [7:0]             db_o,
    output logic                        db_oe_n_o,
    output logic                        req_o,
    output logic                        bsy_o,
    output logic                        sel_o,
    output logic                        cd_o,
    output logic                        io_o,
    output logic                        msg_o,
    // Transfer command from the target's controller
    input  wire logic                   xfer_start_i,
    input  wire logic [2:0]             xfer_phase_i,
    input  wire logic [sctp_pkg::CNT_W-1:0] xfer_count_i,
    input  wire logic                   bus_free_i,
    output logic                        xfer_busy_o,
    output logic                        xfer_done_o,
    output logic                        atn_o,
    output logic                        bus_reset_o,
    // Outbound bytes
    input  wire logic                   tx_valid_i,
    output logic                        tx_ready_o,
    input  wire logic [7:0]             tx_data_i,
    // Inbound bytes
    output logic                        rx_valid_o,
    input  wire logic                   rx_ready_i,
    output logic      [7:0]             rx_data_o
);
    import sctp_pkg::*;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [2:0] sync_s;
    logic       ack_s, atn_s, brst_s;

    sctp_sync #(.W(3)) u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .async_i   ({scsi_rst_i, atn_i, ack_i}),
        .sync_o    (sync_s)
    );
    assign ack_s  = sync_s[0];
    assign atn_s  = sync_s[1];
    assign brst_s = sync_s[2];

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    sctp_state_e            state_q, state_d;
    logic [TMR_W-1:0]       tmr_q, tmr_d;
    logic [CNT_W-1:0]       cnt_q, cnt_d;
    logic [2:0]             phase_q, phase_d;
    logic [7:0]             dout_q, dout_d;
    logic                   oe_q, oe_d;
    logic                   req_q, req_d;
    logic                   bsy_q, bsy_d;
    logic                   done_q, done_d;
    logic                   brst_q;
    logic                   more;
    logic                   start_ok;
    logic                   push;
    logic                   fifo_ready;

    // Message Out keeps going while ATN holds; other phases run to count
    assign more     = (phase_q == PH_MSG_OUT) ? atn_s : (cnt_q != '0);
    // Unused codes are refused so the pins never show them
    assign start_ok = xfer_start_i && (xfer_phase_i != PH_BAD_A)
                      && (xfer_phase_i != PH_BAD_B);
    assign push     = (state_q == ST_RX_REQ) && ack_s && !brst_s;

    always_comb
    begin
        state_d = state_q;
        tmr_d   = tmr_q;
        cnt_d   = cnt_q;
        phase_d = phase_q;
        dout_d  = dout_q;
        oe_d    = oe_q;
        req_d   = req_q;
        bsy_d   = bsy_q;
        done_d  = 1'b0;
        if (brst_s)
        begin
            // Bus reset overrides everything and leaves us at Bus Free
            state_d = ST_FREE;
            tmr_d   = '0;
            cnt_d   = '0;
            phase_d = PH_DATA_OUT;
            oe_d    = 1'b0;
            req_d   = 1'b0;
            bsy_d   = 1'b0;
        end
        else
        begin
            unique case (state_q)
                ST_FREE, ST_HOLD:
                begin
                    if (start_ok)
                    begin
                        // Phase lines change only with REQ low; from Bus Free BSY rises in the same cycle, from hold it stays high
                        state_d = ST_SETTLE;
                        bsy_d   = 1'b1;
                        phase_d = xfer_phase_i;
                        cnt_d   = (xfer_count_i == '0) ? CNT_W'(1) : xfer_count_i;
                        if (!xfer_phase_i[PH_IO])
                            oe_d = 1'b0;
                        if (xfer_phase_i[PH_IO] && !(phase_q[PH_IO] && oe_q))
                            tmr_d = TMR_W'(TURN_CYC);
                        else
                            tmr_d = TMR_W'(SETTLE_CYC);
                    end
                    else if (bus_free_i && state_q == ST_HOLD)
                    begin
                        state_d = ST_FREE;
                        bsy_d   = 1'b0;
                        oe_d    = 1'b0;
                        phase_d = PH_DATA_OUT;
                    end
                end
                ST_SETTLE:
                begin
                    if (tmr_q != '0)
                        tmr_d = tmr_q - 1'b1;
                    else if (phase_q[PH_IO])
                    begin
                        if (tx_valid_i)
                        begin
                            state_d = ST_TX_SETUP;
                            dout_d  = tx_data_i;
                            oe_d    = 1'b1;
                            tmr_d   = TMR_W'(SETUP_CYC);
                        end
                    end
                    else if (fifo_ready)
                    begin
                        // Only ask for a byte when there is room to keep it
                        state_d = ST_RX_REQ;
                        req_d   = 1'b1;
                    end
                end
                ST_TX_SETUP:
                begin
                    if (tmr_q > TMR_W'(1))
                        tmr_d = tmr_q - 1'b1;
                    else
                    begin
                        state_d = ST_TX_REQ;
                        req_d   = 1'b1;
                    end
                end
                ST_TX_REQ:
                begin
                    if (ack_s)
                    begin
                        state_d = ST_TX_REL;
                        req_d   = 1'b0;
                        cnt_d   = cnt_q - 1'b1;
                    end
                end
                ST_RX_REQ:
                begin
                    if (ack_s)
                    begin
                        state_d = ST_RX_REL;
                        req_d   = 1'b0;
                        cnt_d   = cnt_q - 1'b1;
                    end
                end
                ST_TX_REL, ST_RX_REL:
                begin
                    if (!ack_s)
                    begin
                        tmr_d = '0;
                        if (more)
                            state_d = ST_SETTLE;
                        else
                        begin
                            // Phase lines stay valid past the last ACK release
                            state_d = ST_HOLD;
                            done_d  = 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q <= ST_FREE;
            tmr_q   <= '0;
            cnt_q   <= '0;
            phase_q <= PH_DATA_OUT;
            dout_q  <= 8'h00;
            oe_q    <= 1'b0;
            req_q   <= 1'b0;
            bsy_q   <= 1'b0;
            done_q  <= 1'b0;
            brst_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            tmr_q   <= tmr_d;
            cnt_q   <= cnt_d;
            phase_q <= phase_d;
            dout_q  <= dout_d;
            oe_q    <= oe_d;
            req_q   <= req_d;
            bsy_q   <= bsy_d;
            done_q  <= done_d;
            brst_q  <= brst_s;
        end
    end

    // ----------------------------------------------------------------
    // Receive buffer
    // ----------------------------------------------------------------
    // Flushed on bus reset so no byte of an aborted command survives
    sctp_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
        .ref_clk_i  (ref_clk_i),
        .rst_i      (rst_i),
        .flush_i    (brst_s),
        .wr_valid_i (push),
        .wr_ready_o (fifo_ready),
        .wr_data_i  (db_i),
        .rd_valid_o (rx_valid_o),
        .rd_ready_i (rx_ready_i),
        .rd_data_o  (rx_data_o)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign db_o        = dout_q;
    assign db_oe_n_o   = !oe_q;
    assign req_o       = req_q;
    assign bsy_o       = bsy_q;
    assign sel_o       = 1'b0;
    assign io_o        = phase_q[PH_IO];
    assign cd_o        = phase_q[PH_CD];
    assign msg_o       = phase_q[PH_MSG];
    assign xfer_busy_o = (state_q != ST_FREE) && (state_q != ST_HOLD);
    assign xfer_done_o = done_q;
    assign atn_o       = atn_s;
    assign bus_reset_o = brst_s && !brst_q;
    assign tx_ready_o  = (state_q == ST_SETTLE) && (tmr_q == '0) && phase_q[PH_IO]
                         && !brst_s;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_tx_setup;
        @(posedge ref_clk_i) disable iff (rst_i)
        ($rose(req_o) && io_o) |-> (!$past(db_oe_n_o, 1) && !$past(db_oe_n_o, 2));
    endproperty
    a_tx_setup: assert property (p_tx_setup) else $error("REQ rose without data setup");

    property p_tx_hold;
        @(posedge ref_clk_i) disable iff (rst_i)
        (req_o && io_o) |-> (!db_oe_n_o && $stable(db_o));
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("Data moved while REQ high");

    sequence s_ack_seen;
        (state_q == ST_TX_REQ || state_q == ST_RX_REQ) && ack_s;
    endsequence
    property p_req_drop;
        @(posedge ref_clk_i) disable iff (rst_i || brst_s)
        s_ack_seen |=> (!req_o ##1 !req_o);
    endproperty
    a_req_drop: assert property (p_req_drop) else $error("REQ not dropped after ACK");

    property p_next_wait;
        @(posedge ref_clk_i) disable iff (rst_i)
        $rose(req_o) |-> !ack_s;
    endproperty
    a_next_wait: assert property (p_next_wait) else $error("REQ raised with ACK high");

    property p_rx_release;
        @(posedge ref_clk_i) disable iff (rst_i)
        (req_o && !io_o) |-> db_oe_n_o;
    endproperty
    a_rx_release: assert property (p_rx_release) else $error("Driving bus while receiving");

    property p_turn_in;
        @(posedge ref_clk_i) disable iff (rst_i)
        $rose(io_o) |-> db_oe_n_o [*8];
    endproperty
    a_turn_in: assert property (p_turn_in) else $error("Bus driven too soon after I/O");

    property p_phase_legal;
        @(posedge ref_clk_i) disable iff (rst_i)
        bsy_o |-> ({msg_o, cd_o, io_o} != PH_BAD_A && {msg_o, cd_o, io_o} != PH_BAD_B);
    endproperty
    a_phase_legal: assert property (p_phase_legal) else $error("Unused phase code shown");

    property p_envelope;
        @(posedge ref_clk_i) disable iff (rst_i)
        req_o |-> (bsy_o && $stable({msg_o, cd_o, io_o}) && $past(bsy_o, 8));
    endproperty
    a_envelope: assert property (p_envelope) else $error("Phase unstable around REQ");

    property p_bus_reset;
        @(posedge ref_clk_i) disable iff (rst_i)
        brst_s |=> (state_q == ST_FREE && !bsy_o && !req_o && db_oe_n_o);
    endproperty
    a_bus_reset: assert property (p_bus_reset) else $error("Bus reset not honoured");
endmodule

// File: sctp_init_model.sv
// Behavioural initiator answering the target's REQ/ACK handshakes
`timescale 1ns/1ns
module sctp_init_model (
    input  wire logic       ref_clk_i,
    input  wire logic       req_i,
    input  wire logic       io_i,
    input  wire logic [7:0] bus_i,
    input  wire logic [3:0] delay_i,
    input  wire logic       atn_set_i,
    input  wire logic       bsy_i,
    output logic            ack_o,
    output logic            drv_o,
    output logic      [7:0] db_o,
    output logic            atn_o
);
    logic [7:0] out_q[$];
    logic [7:0] in_q[$];
    int         cur_ptr, sav_ptr;

    // ----------------------------------------------------------------
    // Handshake loop
    // ----------------------------------------------------------------
    // Terminated bus: released lines read negated, so drv_o low means zero
    initial
    begin
        ack_o = 1'b0;
        drv_o = 1'b0;
        db_o  = 8'h00;
        atn_o = 1'b0;
        // Saved set stays at zero as no save is ever requested here
        cur_ptr = 0;
        sav_ptr = 0;
        forever
        begin
            @(posedge ref_clk_i);
            // Disconnected: only the saved set survives
            if (!bsy_i)
                cur_ptr = sav_ptr;
            if (atn_set_i)
                atn_o <= 1'b1;
            if (req_i && !ack_o)
            begin
                if (io_i)
                    in_q.push_back(bus_i);
                else
                begin
                    db_o  <= out_q.pop_front();
                    drv_o <= 1'b1;
                    // Drop ATN while REQ is true and ACK false on the last byte
                    if (out_q.size() == 0)
                        atn_o <= 1'b0;
                end
                repeat (2 + delay_i) @(posedge ref_clk_i);
                // A cut handshake gets no ACK, so ACK is never set and cleared at once
                if (req_i)
                begin
                    ack_o <= 1'b1;
                    cur_ptr++;
                end
                while (req_i) @(posedge ref_clk_i);
                drv_o <= 1'b0;
                ack_o <= 1'b0;
            end
        end
    end
endmodule

// File: testbench.sv
// Self-checking bench for the target transfer phases
`timescale 1ns/1ns
module testbench;
    import sctp_pkg::*;
    logic             ref_clk_i, rst_i, ack_i, atn_i, scsi_rst_i, xfer_start_i, bus_free_i;
    logic             tx_valid_i, rx_ready_i, req_o, bsy_o, sel_o, cd_o, io_o, msg_o;
    logic             db_oe_n_o, xfer_busy_o, xfer_done_o, atn_o, bus_reset_o;
    logic             tx_ready_o, rx_valid_o, m_drv, atn_set, req_prev, oe_prev;
    logic [7:0]       db_i, db_o, tx_data_i, rx_data_o, m_db, db_prev;
    logic [2:0]       xfer_phase_i;
    logic [CNT_W-1:0] xfer_count_i;
    logic [3:0]       dly;
    logic [7:0]       tx_q[$], rx_q[$];
    int               miscompares, cmp_count, io_cnt, lo_cnt, drv_cnt;

    // ----------------------------------------------------------------
    // Design, initiator and bus wiring
    // ----------------------------------------------------------------
    sctp_target sctp_target_i (
        .ref_clk_i, .rst_i, .ack_i, .atn_i, .scsi_rst_i, .db_i, .db_o, .db_oe_n_o, .req_o,
        .bsy_o, .sel_o, .cd_o, .io_o, .msg_o, .xfer_start_i, .xfer_phase_i, .xfer_count_i,
        .bus_free_i, .xfer_busy_o, .xfer_done_o, .atn_o, .bus_reset_o, .tx_valid_i,
        .tx_ready_o, .tx_data_i, .rx_valid_o, .rx_ready_i, .rx_data_o
    );
    sctp_init_model sctp_init_model_i (
        .ref_clk_i(ref_clk_i), .req_i(req_o), .io_i(io_o), .bus_i(db_i), .delay_i(dly),
        .atn_set_i(atn_set), .bsy_i(bsy_o), .ack_o(ack_i), .drv_o(m_drv), .db_o(m_db),
        .atn_o(atn_i)
    );
    assign db_i = !db_oe_n_o ? db_o : (m_drv ? m_db : 8'h00);

    initial
    begin
        ref_clk_i = 1'b0;
        forever #(CLK_PERIOD_NS / 2) ref_clk_i = ~ref_clk_i;
    end

    always @(negedge ref_clk_i)
    begin
        tx_valid_i <= tx_q.size() > 0;
        tx_data_i  <= tx_q.size() > 0 ? tx_q[0] : 8'h00;
    end

    always @(posedge ref_clk_i)
    begin
        if (tx_valid_i && tx_ready_o)
            void'(tx_q.pop_front());
        if (rx_valid_o && rx_ready_i)
            rx_q.push_back(rx_data_o);
    end

    // ----------------------------------------------------------------
    // Compare tasks and bus watch
    // ----------------------------------------------------------------
    task automatic chk_b(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask

    task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask

    // drv_cnt and lo_cnt are updated before the checks so they hold whole cycles seen; io_cnt is updated after them
    always @(posedge ref_clk_i)
    begin
        drv_cnt = (db_oe_n_o || oe_prev || db_o !== db_prev) ? 0 : drv_cnt + 1;
        lo_cnt  = io_o ? 0 : lo_cnt + 1;
        if (!rst_i)
        begin
            if (req_o && !req_prev && io_o)
                chk_b(drv_cnt >= SETUP_CYC, 1'b1);
            if (req_o && !req_prev)
                chk_b(ack_i, 1'b0);
            if (req_o)
                chk_b(bsy_o && !sel_o, 1'b1);
            if (bsy_o && !xfer_busy_o)
                chk_b(req_o, 1'b0);
            if (!db_oe_n_o && oe_prev)
                chk_b(io_cnt >= TURN_CYC, 1'b1);
            if (lo_cnt >= 2)
                chk_b(db_oe_n_o, 1'b1);
            chk_b(!db_oe_n_o && m_drv, 1'b0);
        end
        io_cnt   = io_o ? io_cnt + 1 : 0;
        db_prev  = db_o;
        req_prev = req_o;
        oe_prev  = db_oe_n_o;
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask

    task automatic go(input logic [2:0] ph, input int n);
        @(negedge ref_clk_i);
        xfer_phase_i = ph;
        xfer_count_i = n[CNT_W-1:0];
        xfer_start_i = 1'b1;
        @(negedge ref_clk_i);
        xfer_start_i = 1'b0;
    endtask

    task automatic wait_done();
        int i;
        i = 0;
        while (xfer_done_o !== 1'b1 && i < 3000)
        begin
            cyc(1);
            i++;
        end
        chk_b(xfer_done_o, 1'b1);
    endtask

    task automatic s_send(input logic [2:0] ph, input int n, input logic [3:0] d);
        dly = d;
        sctp_init_model_i.in_q.delete();
        for (int i = 0; i < n; i++)
            tx_q.push_back({ph, i[4:0]});
        go(ph, n);
        cyc(1);
        chk_v({5'h0, msg_o, cd_o, io_o}, {5'h0, ph});
        wait_done();
        chk_v(8'(sctp_init_model_i.in_q.size()), 8'(n));
        for (int i = 0; i < n; i++)
            chk_v(sctp_init_model_i.in_q[i], {ph, i[4:0]});
    endtask

    task automatic s_recv(input logic [2:0] ph, input int n, input int hold);
        rx_q.delete();
        for (int i = 0; i < n; i++)
            sctp_init_model_i.out_q.push_back({ph, i[4:0]});
        rx_ready_i = (hold == 0);
        go(ph, n);
        cyc(1);
        chk_v({5'h0, msg_o, cd_o, io_o}, {5'h0, ph});
        if (hold > 0)
        begin
            cyc(hold);
            chk_v(8'(sctp_init_model_i.out_q.size()), 8'(n - FIFO_D));
            chk_b(req_o, 1'b0);
            rx_ready_i = 1'b1;
        end
        wait_done();
        cyc(3);
        chk_v(8'(rx_q.size()), 8'(n));
        for (int i = 0; i < n; i++)
            chk_v(rx_q[i], {ph, i[4:0]});
    endtask

    task automatic s_refuse();
        go(PH_BAD_A, 1);
        go(PH_BAD_B, 1);
        cyc(3);
        chk_b(bsy_o, 1'b0);
    endtask

    task automatic s_mout();
        atn_set = 1'b1;
        cyc(1);
        atn_set = 1'b0;
        cyc(8);
        chk_b(atn_o, 1'b1);
        s_recv(PH_MSG_OUT, 3, 0);
    endtask

    task automatic s_busfree();
        chk_v(8'(sctp_init_model_i.cur_ptr), 8'h12);
        bus_free_i = 1'b1;
        cyc(1);
        bus_free_i = 1'b0;
        cyc(2);
        chk_v({4'h0, bsy_o, msg_o, cd_o, io_o}, 8'h00);
        chk_v(8'(sctp_init_model_i.cur_ptr), 8'h00);
    endtask

    // Bus reset lands while a slow initiator is in mid handshake
    task automatic s_rst_mid();
        int i;
        for (i = 0; i < 4; i++)
            sctp_init_model_i.out_q.push_back(8'h77);
        dly = 4'hf;
        go(PH_DATA_OUT, 4);
        cyc(40);
        scsi_rst_i = 1'b1;
        i = 0;
        while (bus_reset_o !== 1'b1 && i < 10)
        begin
            cyc(1);
            i++;
        end
        chk_b(bus_reset_o, 1'b1);
        cyc(2);
        chk_b(bsy_o || req_o || !db_oe_n_o || rx_valid_o, 1'b0);
        go(PH_DATA_IN, 1);
        cyc(3);
        chk_b(bsy_o, 1'b0);
        scsi_rst_i = 1'b0;
        cyc(40);
        sctp_init_model_i.out_q.delete();
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        #(CLK_PERIOD_NS * 20000);
        miscompares++;
        end_sim();
    end

    initial
    begin
        rst_i        = 1'b1;
        scsi_rst_i   = 1'b0;
        xfer_start_i = 1'b0;
        xfer_phase_i = 3'h0;
        xfer_count_i = '0;
        bus_free_i   = 1'b0;
        rx_ready_i   = 1'b1;
        atn_set      = 1'b0;
        dly          = 4'h0;
        repeat (3) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        rst_i = 1'b0;
        chk_b(bsy_o || req_o || xfer_busy_o || rx_valid_o || !db_oe_n_o, 1'b0);
        s_refuse();
        s_recv(PH_COMMAND, 6, 300);
        s_send(PH_DATA_IN, 3, 0);
        s_send(PH_STATUS, 1, 5);
        s_send(PH_STATUS, 1, 0);
        s_send(PH_MSG_IN, 2, 5);
        s_recv(PH_DATA_OUT, 2, 0);
        s_mout();
        s_busfree();
        s_rst_mid();
        s_send(PH_STATUS, 1, 0);
        end_sim();
    end
endmodule
